// >>> include/timer16_consts.svh
// Register offsets, field positions, reset values and clock select codes of the 16-bit timer
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

// ==========================================================
// Register offsets
`define T16_ADDR_FLAGS 8'h36
`define T16_ADDR_MASK 8'h6f
`define T16_ADDR_CTRL_A 8'h80
`define T16_ADDR_CTRL_B 8'h81
`define T16_ADDR_FORCE 8'h82
`define T16_ADDR_CNT_L 8'h84
`define T16_ADDR_CNT_H 8'h85
`define T16_ADDR_CAP_L 8'h86
`define T16_ADDR_CAP_H 8'h87
`define T16_ADDR_CMPA_L 8'h88
`define T16_ADDR_CMPA_H 8'h89
`define T16_ADDR_CMPB_L 8'h8a
`define T16_ADDR_CMPB_H 8'h8b

// ==========================================================
// Field positions
`define T16_IRQ_CAPTURE_BIT 5
`define T16_IRQ_CMPB_BIT 2
`define T16_IRQ_CMPA_BIT 1
`define T16_IRQ_OVF_BIT 0
`define T16_CTLB_FILTER_BIT 7
`define T16_CTLB_EDGE_BIT 6
`define T16_FORCE_A_BIT 7
`define T16_FORCE_B_BIT 6

// ==========================================================
// Reset values
`define T16_RESET_BYTE 8'h00
`define T16_RESET_WORD 16'h0000

// ==========================================================
// Clock select codes and prescaler widths
`define T16_CS_STOP 3'h0
`define T16_CS_DIV1 3'h1
`define T16_CS_DIV8 3'h2
`define T16_CS_DIV64 3'h3
`define T16_CS_DIV256 3'h4
`define T16_CS_DIV1024 3'h5
`define T16_CS_EXT_FALL 3'h6
`define T16_CS_EXT_RISE 3'h7
`define T16_PRESC_BITS 10
`define T16_FILTER_SAMPLES 4

`endif

// >>> include/timer16_pkg.sv
// Types shared by the 16-bit timer modules
package timer16_pkg;
   typedef logic [15:0] word_t;
   typedef logic [7:0] byte_t;
   typedef enum logic [2:0] {
      KIND_NORMAL = 3'b000,
      KIND_CLEAR = 3'b001,
      KIND_FAST = 3'b010,
      KIND_PHASE = 3'b011,
      KIND_PFC = 3'b100
   } mode_kind_t;
endpackage

// >>> include/capture_if.sv
// Link between the timer core and its capture front end
`timescale 1ns/10ps
interface capture_if;
   logic level;
   logic filter_en;
   logic rising;
   logic enable;
   logic capture_event;
   modport front (input level, input filter_en, input rising, input enable, output capture_event);
   modport core (output level, output filter_en, output rising, output enable,
      input capture_event);
endinterface // capture_if

// >>> src/capture_front.sv
// Capture input noise filter and edge detector
`timescale 1ns/10ps
`include "timer16_consts.svh"
module capture_front #(
   parameter int FILTER_DEPTH = `T16_FILTER_SAMPLES
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Link to the core
   capture_if.front cap
);
   logic [FILTER_DEPTH-1:0] samples;
   logic filtered;
   logic prev;
   logic chosen;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         samples <= '0;
      end else begin
         samples <= {samples[FILTER_DEPTH-2:0], cap.level};
      end
   end

   // Output moves only after a run of equal samples
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         filtered <= 1'b0;
      end else if (&samples) begin
         filtered <= 1'b1;
      end else if (~|samples) begin
         filtered <= 1'b0;
      end
   end

   assign chosen = cap.filter_en ? filtered : samples[0];

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         prev <= 1'b0;
      end else begin
         prev <= chosen;
      end
   end

   // Edge choice: falling when low, rising when high
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         cap.capture_event <= 1'b0;
      end else begin
         cap.capture_event <= cap.enable &&
            (cap.rising ? (chosen && !prev) : (!chosen && prev));
      end
   end
endmodule // capture_front

// >>> src/timer16.sv
// 16-bit timer with two compare channels and one capture channel
// What this block does
// - Capture triggers on falling edge when edge select is zero, rising when one.
// - Capture copies counter into capture register and sets the capture flag.
// - Modes using capture register as top disconnect the capture input.
// - Clock select: stop, /1, /8, /64, /256, /1024, external falling, rising.
// - External count pin clocks the counter even when used as an output.
// - Force bits apply an immediate compare action in non-PWM modes.
// - Forced compare never raises an interrupt nor clears the counter.
// - Force bits are one-cycle strobes and always read zero.
// - All 16-bit registers share one high-byte latch for atomic transfer.
// - Counter write blocks every compare match on the next timer tick.
// - Compare registers match counter continuously; match drives flag and output.
// - Capture register loads counter on pin or comparator event; may be top.
// - Mask holds capture, compare B, A, overflow enables; request needs all three.
// - Unused bits 7:6 and 4:3 of mask and flags read zero.
// - Capture flag sets on capture, or at top when capture register is top.
// - Compare flag sets on the tick after counter equals compare value.
// - Forced compare does not set the compare flag.
// - Overflow flag sets on overflow in normal and clear-on-compare, else per mode.
// - Flags clear on vector acknowledge or by writing one.
// - Four-bit mode picks sequence, top, compare update and overflow point.
// - Capture filter needs four equal samples before its output changes.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`include "timer16_consts.svh"
module timer16 (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   // Register port
   input wire logic [7:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [7:0] RDATA_OUT,
   // Interrupt requests, bit 3 capture, 2 compare B, 1 compare A, 0 overflow
   input wire logic GLOBAL_IRQ_EN_IN,
   input wire logic [3:0] IRQ_ACK_IN,
   output logic [3:0] IRQ_REQ_OUT,
   // Capture and count pins
   input wire logic CAPTURE_PIN_IN,
   input wire logic ANALOG_CMP_IN,
   input wire logic ANALOG_CAPTURE_SEL_IN,
   input wire logic EXT_COUNT_PIN_IN,
   // Waveform pins
   output logic WAVE_A_OUT,
   output logic WAVE_A_OE_N_OUT,
   output logic WAVE_B_OUT,
   output logic WAVE_B_OE_N_OUT
);
   // ==========================================================
   // Mode decoding
   function automatic timer16_pkg::mode_kind_t kind_of(input logic [3:0] m);
      case (m)
         4'h4, 4'hc: kind_of = timer16_pkg::KIND_CLEAR;
         4'h5, 4'h6, 4'h7, 4'he, 4'hf: kind_of = timer16_pkg::KIND_FAST;
         4'h1, 4'h2, 4'h3, 4'ha, 4'hb: kind_of = timer16_pkg::KIND_PHASE;
         4'h8, 4'h9: kind_of = timer16_pkg::KIND_PFC;
         default: kind_of = timer16_pkg::KIND_NORMAL;
      endcase
   endfunction

   function automatic logic icr_is_top(input logic [3:0] m);
      icr_is_top = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
   endfunction

   function automatic timer16_pkg::word_t top_of(input logic [3:0] m,
      input timer16_pkg::word_t oa, input timer16_pkg::word_t ic);
      if (icr_is_top(m)) begin
         top_of = ic;
      end else begin
         case (m)
            4'h1, 4'h5: top_of = 16'h00ff;
            4'h2, 4'h6: top_of = 16'h01ff;
            4'h3, 4'h7: top_of = 16'h03ff;
            4'h4, 4'h9, 4'hb, 4'hf: top_of = oa;
            default: top_of = 16'hffff;
         endcase
      end
   endfunction

   // Internal flag order {capture, cmp B, cmp A, overflow} to register layout
   function automatic timer16_pkg::byte_t pack_irq(input logic [3:0] b);
      pack_irq = `T16_RESET_BYTE;
      pack_irq[`T16_IRQ_CAPTURE_BIT] = b[3];
      pack_irq[`T16_IRQ_CMPB_BIT] = b[2];
      pack_irq[`T16_IRQ_CMPA_BIT] = b[1];
      pack_irq[`T16_IRQ_OVF_BIT] = b[0];
   endfunction

   function automatic logic [3:0] unpack_irq(input timer16_pkg::byte_t d);
      unpack_irq = {d[`T16_IRQ_CAPTURE_BIT], d[`T16_IRQ_CMPB_BIT],
         d[`T16_IRQ_CMPA_BIT], d[`T16_IRQ_OVF_BIT]};
   endfunction

   // ==========================================================
   // State
   logic [1:0] com [0:1];
   logic [3:0] wgm;
   logic [1:0] mode_lo;
   logic [1:0] mode_hi;
   assign wgm = {mode_hi, mode_lo};
   logic [2:0] clk_sel;
   logic filter_en;
   logic edge_rise;
   timer16_pkg::word_t cnt;
   timer16_pkg::word_t icr;
   timer16_pkg::word_t ocr_buf [0:1];
   timer16_pkg::word_t ocr [0:1];
   timer16_pkg::byte_t temp;
   logic [3:0] mask;
   logic [3:0] flags;
   logic [`T16_PRESC_BITS-1:0] presc;
   logic ext_prev;
   logic dir_down;
   logic block;
   logic [1:0] wave;
   logic [1:0] wave_oe_n;

   timer16_pkg::mode_kind_t kind;
   timer16_pkg::word_t top;
   timer16_pkg::word_t next_cnt;
   logic next_down;
   logic tick;
   logic at_top;
   logic non_pwm;
   logic ocr_update;
   logic ovf_event;
   logic cap_set;
   logic [1:0] match;
   logic [1:0] force_cmp;
   logic [3:0] next_flags;

   // ==========================================================
   // Register decode
   logic wr_flags, wr_mask, wr_ctl_a, wr_ctl_b, wr_force;
   logic wr_cnt_l, wr_cap_l, wr_cmpa_l, wr_cmpb_l, wr_high;
   assign wr_flags = WR_IN && (ADDR_IN == `T16_ADDR_FLAGS);
   assign wr_mask = WR_IN && (ADDR_IN == `T16_ADDR_MASK);
   assign wr_ctl_a = WR_IN && (ADDR_IN == `T16_ADDR_CTRL_A);
   assign wr_ctl_b = WR_IN && (ADDR_IN == `T16_ADDR_CTRL_B);
   assign wr_force = WR_IN && (ADDR_IN == `T16_ADDR_FORCE);
   assign wr_cnt_l = WR_IN && (ADDR_IN == `T16_ADDR_CNT_L);
   assign wr_cap_l = WR_IN && (ADDR_IN == `T16_ADDR_CAP_L);
   assign wr_cmpa_l = WR_IN && (ADDR_IN == `T16_ADDR_CMPA_L);
   assign wr_cmpb_l = WR_IN && (ADDR_IN == `T16_ADDR_CMPB_L);
   assign wr_high = WR_IN && ((ADDR_IN == `T16_ADDR_CNT_H) || (ADDR_IN == `T16_ADDR_CAP_H) ||
      (ADDR_IN == `T16_ADDR_CMPA_H) || (ADDR_IN == `T16_ADDR_CMPB_H));

   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         com[0] <= 2'h0;
         com[1] <= 2'h0;
         mode_lo <= 2'h0;
      end else if (wr_ctl_a) begin
         com[0] <= WDATA_IN[7:6];
         com[1] <= WDATA_IN[5:4];
         mode_lo <= WDATA_IN[1:0];
      end
   end

   // Bit 5 is dropped, so a stray one from software has no effect
   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         filter_en <= 1'b0;
         edge_rise <= 1'b0;
         mode_hi <= 2'h0;
         clk_sel <= `T16_CS_STOP;
      end else if (wr_ctl_b) begin
         filter_en <= WDATA_IN[`T16_CTLB_FILTER_BIT];
         edge_rise <= WDATA_IN[`T16_CTLB_EDGE_BIT];
         mode_hi <= WDATA_IN[4:3];
         clk_sel <= WDATA_IN[2:0];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         mask <= 4'h0;
      end else if (wr_mask) begin
         mask <= unpack_irq(WDATA_IN);
      end
   end

   // Shared high-byte latch: high writes and low reads load it
   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         temp <= `T16_RESET_BYTE;
      end else if (wr_high) begin
         temp <= WDATA_IN;
      end else if (RD_IN) begin
         case (ADDR_IN)
            `T16_ADDR_CNT_L: temp <= cnt[15:8];
            `T16_ADDR_CAP_L: temp <= icr[15:8];
            `T16_ADDR_CMPA_L: temp <= ocr_buf[0][15:8];
            `T16_ADDR_CMPB_L: temp <= ocr_buf[1][15:8];
            default: temp <= temp;
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN || !RD_IN) begin
         RDATA_OUT <= `T16_RESET_BYTE;
      end else begin
         case (ADDR_IN)
            `T16_ADDR_FLAGS: RDATA_OUT <= pack_irq(flags);
            `T16_ADDR_MASK: RDATA_OUT <= pack_irq(mask);
            `T16_ADDR_CTRL_A: RDATA_OUT <= {com[0], com[1], 2'h0, wgm[1:0]};
            `T16_ADDR_CTRL_B: RDATA_OUT <= {filter_en, edge_rise, 1'b0, wgm[3:2], clk_sel};
            `T16_ADDR_FORCE: RDATA_OUT <= `T16_RESET_BYTE;
            `T16_ADDR_CNT_L: RDATA_OUT <= cnt[7:0];
            `T16_ADDR_CAP_L: RDATA_OUT <= icr[7:0];
            `T16_ADDR_CMPA_L: RDATA_OUT <= ocr_buf[0][7:0];
            `T16_ADDR_CMPB_L: RDATA_OUT <= ocr_buf[1][7:0];
            `T16_ADDR_CNT_H, `T16_ADDR_CAP_H, `T16_ADDR_CMPA_H, `T16_ADDR_CMPB_H: begin
               RDATA_OUT <= temp;
            end
            default: RDATA_OUT <= `T16_RESET_BYTE;
         endcase
      end
   end

   // ==========================================================
   // Clock selection
   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         presc <= '0;
         ext_prev <= 1'b0;
      end else begin
         presc <= presc + 1'b1;
         ext_prev <= EXT_COUNT_PIN_IN;
      end
   end

   always_comb begin
      case (clk_sel)
         `T16_CS_DIV1: tick = 1'b1;
         `T16_CS_DIV8: tick = &presc[2:0];
         `T16_CS_DIV64: tick = &presc[5:0];
         `T16_CS_DIV256: tick = &presc[7:0];
         `T16_CS_DIV1024: tick = &presc[9:0];
         `T16_CS_EXT_FALL: tick = ext_prev && !EXT_COUNT_PIN_IN;
         `T16_CS_EXT_RISE: tick = !ext_prev && EXT_COUNT_PIN_IN;
         default: tick = 1'b0;
      endcase
   end

   // ==========================================================
   // Counter sequence
   assign kind = kind_of(wgm);
   assign top = top_of(wgm, ocr[0], icr);
   assign at_top = (cnt == top);
   assign non_pwm = (kind == timer16_pkg::KIND_NORMAL) || (kind == timer16_pkg::KIND_CLEAR);

   always_comb begin
      next_cnt = cnt;
      next_down = dir_down;
      if (tick) begin
         if (kind == timer16_pkg::KIND_PHASE || kind == timer16_pkg::KIND_PFC) begin
            if (dir_down && cnt == 16'h0000) begin
               next_down = 1'b0;
               next_cnt = 16'(cnt + 16'h0001);
            end else if (dir_down || (cnt >= top)) begin
               next_down = 1'b1;
               next_cnt = 16'(cnt - 16'h0001);
            end else begin
               next_cnt = 16'(cnt + 16'h0001);
            end
         end else if (at_top) begin
            next_cnt = 16'h0000;
         end else begin
            next_cnt = 16'(cnt + 16'h0001);
         end
      end
   end

   // A CPU write takes priority over counting and arms the match block
   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         cnt <= `T16_RESET_WORD;
         dir_down <= 1'b0;
         block <= 1'b0;
      end else if (wr_cnt_l) begin
         cnt <= {temp, WDATA_IN};
         dir_down <= next_down;
         block <= 1'b1;
      end else begin
         cnt <= next_cnt;
         dir_down <= next_down;
         if (tick) begin
            block <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Compare registers and double buffering
   always_comb begin
      case (kind)
         timer16_pkg::KIND_FAST: ocr_update = tick && at_top;
         timer16_pkg::KIND_PHASE: ocr_update = tick && at_top && !dir_down;
         timer16_pkg::KIND_PFC: ocr_update = tick && dir_down && (cnt == 16'h0000);
         default: ocr_update = 1'b1;
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         ocr_buf[0] <= `T16_RESET_WORD;
         ocr_buf[1] <= `T16_RESET_WORD;
         ocr[0] <= `T16_RESET_WORD;
         ocr[1] <= `T16_RESET_WORD;
      end else begin
         if (wr_cmpa_l) begin
            ocr_buf[0] <= {temp, WDATA_IN};
         end
         if (wr_cmpb_l) begin
            ocr_buf[1] <= {temp, WDATA_IN};
         end
         if (ocr_update) begin
            ocr[0] <= ocr_buf[0];
            ocr[1] <= ocr_buf[1];
         end
      end
   end

   // Matches are judged on the value held before the tick
   assign match[0] = tick && !block && (cnt == ocr[0]);
   assign match[1] = tick && !block && (cnt == ocr[1]);
   assign force_cmp[0] = wr_force && WDATA_IN[`T16_FORCE_A_BIT] && non_pwm;
   assign force_cmp[1] = wr_force && WDATA_IN[`T16_FORCE_B_BIT] && non_pwm;

   // ==========================================================
   // Capture unit
   capture_if cap_link ();
   assign cap_link.level = ANALOG_CAPTURE_SEL_IN ? ANALOG_CMP_IN : CAPTURE_PIN_IN;
   assign cap_link.filter_en = filter_en;
   assign cap_link.rising = edge_rise;
   assign cap_link.enable = !icr_is_top(wgm);

   capture_front u_capture_front (
      .clk_in(CLK_IN),
      .resetn_in(RESETN_IN),
      .cap(cap_link)
   );

   // A capture event wins over a simultaneous software write
   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         icr <= `T16_RESET_WORD;
      end else if (cap_link.capture_event) begin
         icr <= cnt;
      end else if (wr_cap_l) begin
         icr <= {temp, WDATA_IN};
      end
   end

   // ==========================================================
   // Flags and interrupt requests
   always_comb begin
      case (kind)
         timer16_pkg::KIND_NORMAL, timer16_pkg::KIND_CLEAR: ovf_event = tick && (cnt == 16'hffff);
         timer16_pkg::KIND_FAST: ovf_event = tick && at_top;
         default: ovf_event = tick && dir_down && (cnt == 16'h0000);
      endcase
   end

   assign cap_set = cap_link.capture_event || (icr_is_top(wgm) && tick && at_top);

   // Force strobes reach no flag, and a set beats a clear in the same cycle
   always_comb begin
      next_flags = flags & ~IRQ_ACK_IN;
      if (wr_flags) begin
         next_flags = next_flags & ~unpack_irq(WDATA_IN);
      end
      next_flags = next_flags | {cap_set, match[1], match[0], ovf_event};
   end

   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         flags <= 4'h0;
      end else begin
         flags <= next_flags;
      end
   end

   assign IRQ_REQ_OUT = flags & mask & {4{GLOBAL_IRQ_EN_IN}};

   // ==========================================================
   // Waveform generation
   for (genvar i = 0; i < 2; i++) begin : g_chan
      logic w;
      logic nw;
      logic toggle_ok;

      always_comb begin
         case (kind)
            timer16_pkg::KIND_FAST: toggle_ok = (i == 0) && (wgm[3:1] == 3'h7);
            timer16_pkg::KIND_PHASE, timer16_pkg::KIND_PFC: begin
               toggle_ok = (i == 0) && (wgm == 4'h9 || wgm == 4'hb);
            end
            default: toggle_ok = 1'b1;
         endcase
      end

      always_comb begin
         nw = w;
         if (com[i] == 2'h1) begin
            if (toggle_ok && (match[i] || force_cmp[i])) begin
               nw = !w;
            end
         end else if (com[i] != 2'h0) begin
            if (non_pwm) begin
               if (match[i] || force_cmp[i]) begin
                  nw = com[i][0];
               end
            end else if (kind == timer16_pkg::KIND_FAST) begin
               // Bottom action wins, so a compare equal to top is ignored
               if (tick && at_top) begin
                  nw = !com[i][0];
               end else if (match[i]) begin
                  nw = com[i][0];
               end
            end else if (match[i]) begin
               nw = com[i][0] ^ dir_down;
            end
         end
      end

      always_ff @(posedge CLK_IN) begin
         if (!RESETN_IN) begin
            w <= 1'b0;
         end else begin
            w <= nw;
         end
      end

      assign wave[i] = w;
      assign wave_oe_n[i] = (com[i] == 2'h0) || (com[i] == 2'h1 && !toggle_ok);
   end

   assign WAVE_A_OUT = wave[0];
   assign WAVE_B_OUT = wave[1];
   assign WAVE_A_OE_N_OUT = wave_oe_n[0];
   assign WAVE_B_OE_N_OUT = wave_oe_n[1];
endmodule // timer16

// >>> test/timer16_asserts.sv
// Port-level checker for the 16-bit timer
`timescale 1ns/10ps
`include "timer16_consts.svh"
module timer16_asserts (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   // Register port
   input wire logic [7:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [7:0] RDATA_OUT,
   // Interrupts
   input wire logic GLOBAL_IRQ_EN_IN,
   input wire logic [3:0] IRQ_ACK_IN,
   input wire logic [3:0] IRQ_REQ_OUT
);
   // ==========
   // Properties
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   a_req_gated: assert property (!GLOBAL_IRQ_EN_IN |-> IRQ_REQ_OUT == 4'h0)
      else $error("request while globally disabled");
   a_mask_off: assert property (WR_IN && ADDR_IN == `T16_ADDR_MASK && WDATA_IN == 8'h00
      |=> IRQ_REQ_OUT == 4'h0)
      else $error("request after mask cleared");
   a_req_kept: assert property (!WR_IN && IRQ_ACK_IN == 4'h0 && GLOBAL_IRQ_EN_IN
      |=> !GLOBAL_IRQ_EN_IN || (IRQ_REQ_OUT & $past(IRQ_REQ_OUT)) == $past(IRQ_REQ_OUT))
      else $error("request dropped without clear");
   a_force_zero: assert property (RD_IN && ADDR_IN == `T16_ADDR_FORCE
      |=> RDATA_OUT == 8'h00)
      else $error("force register read nonzero");
   a_unused_zero: assert property (RD_IN && (ADDR_IN == `T16_ADDR_MASK
      || ADDR_IN == `T16_ADDR_FLAGS) |=> (RDATA_OUT & 8'hd8) == 8'h00)
      else $error("unused bits read nonzero");
   a_ctrlb_res: assert property (RD_IN && ADDR_IN == `T16_ADDR_CTRL_B
      |=> !RDATA_OUT[5])
      else $error("reserved control bit read set");
   a_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
      else $error("read data outside its cycle");
   a_mask_back: assert property (WR_IN && ADDR_IN == `T16_ADDR_MASK ##1 !WR_IN
      ##1 RD_IN && ADDR_IN == `T16_ADDR_MASK |=> RDATA_OUT == ($past(WDATA_IN, 3) & 8'h27))
      else $error("mask readback wrong");
endmodule // timer16_asserts

bind timer16 timer16_asserts u_timer16_asserts (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
   .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
   .RDATA_OUT(RDATA_OUT), .GLOBAL_IRQ_EN_IN(GLOBAL_IRQ_EN_IN), .IRQ_ACK_IN(IRQ_ACK_IN),
   .IRQ_REQ_OUT(IRQ_REQ_OUT));

// >>> test/pin_driver.sv
// Far-side model driving the capture and external count pins
`timescale 1ns/10ps
module pin_driver (
   // Clock
   input wire logic clk_in,
   // Pins
   output logic cap_out,
   output logic ext_out
);
   // ==========
   // Pin tasks, levels held several cycles so the sampler sees each one
   initial begin
      cap_out = 1'b1;
      ext_out = 1'b0;
   end
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk_in);
         ext_out <= 1'b1;
         repeat (3) @(posedge clk_in);
         ext_out <= 1'b0;
         repeat (3) @(posedge clk_in);
      end
   endtask
   task automatic cap_to(input logic v);
      @(posedge clk_in);
      cap_out <= v;
      repeat (10) @(posedge clk_in);
   endtask
endmodule // pin_driver

// >>> test/timer16_tb.sv
// Register-level testbench of the 16-bit timer
`timescale 1ns/10ps
`include "timer16_consts.svh"
module timer16_tb;
   logic clk, rstn, wr, rd, gie, cap, ext, ana, asel, wa, wb, wa_oe_n, wb_oe_n;
   logic [7:0] addr, wdata;
   logic [3:0] ack, req;
   timer16_pkg::byte_t rdata, d;
   timer16_pkg::word_t w;
   logic [7:0] regs [4] = '{`T16_ADDR_FLAGS, `T16_ADDR_MASK, `T16_ADDR_FORCE, `T16_ADDR_CTRL_B};
   int errors = 0;
   int checks = 0;
   timer16 u_timer16 (.CLK_IN(clk), .RESETN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .GLOBAL_IRQ_EN_IN(gie), .IRQ_ACK_IN(ack),
      .IRQ_REQ_OUT(req), .CAPTURE_PIN_IN(cap), .ANALOG_CMP_IN(ana),
      .ANALOG_CAPTURE_SEL_IN(asel), .EXT_COUNT_PIN_IN(ext), .WAVE_A_OUT(wa),
      .WAVE_A_OE_N_OUT(wa_oe_n), .WAVE_B_OUT(wb), .WAVE_B_OE_N_OUT(wb_oe_n));
   pin_driver u_pin_driver (.clk_in(clk), .cap_out(cap), .ext_out(ext));
   // ==========
   // Bus tasks
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string n, input timer16_pkg::word_t e, input timer16_pkg::word_t s);
      checks++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr8(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd8(input logic [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // High byte goes first into the shared latch; the low write commits
   task automatic wr16(input logic [7:0] a, input timer16_pkg::word_t v);
      wr8(a + 8'h01, v[15:8]);
      wr8(a, v[7:0]);
   endtask
   task automatic rd16(input logic [7:0] a);
      rd8(a);
      w[7:0] = d;
      rd8(a + 8'h01);
      w[15:8] = d;
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      wrap_up;
   end
   // ==========
   // Tests
   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      gie = 1'b0;
      ack = 4'h0;
      ana = 1'b1;
      asel = 1'b0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      foreach (regs[i]) begin
         rd8(regs[i]);
         chk("reset", 16'h0000, d);
      end
      wr8(`T16_ADDR_MASK, 8'hff);
      rd8(`T16_ADDR_MASK);
      chk("mask", 16'h0027, d);
      wr8(`T16_ADDR_FORCE, 8'hc0);
      rd8(`T16_ADDR_FORCE);
      chk("force", 16'h0000, d);
      wr16(`T16_ADDR_CNT_L, 16'h1234);
      rd16(`T16_ADDR_CNT_L);
      chk("cnt", 16'h1234, w);
      wr8(`T16_ADDR_CMPA_H, 8'h55);
      wr8(`T16_ADDR_CNT_L, 8'h66);
      rd16(`T16_ADDR_CNT_L);
      chk("latch", 16'h5566, w);
      $display("register test done");
      wr16(`T16_ADDR_CNT_L, 16'h0000);
      wr8(`T16_ADDR_CTRL_B, 8'h07);
      u_pin_driver.pulse(3);
      rd16(`T16_ADDR_CNT_L);
      chk("rise", 16'h0003, w);
      wr8(`T16_ADDR_CTRL_B, 8'h06);
      u_pin_driver.pulse(2);
      wr8(`T16_ADDR_CTRL_B, 8'h00);
      u_pin_driver.pulse(2);
      rd16(`T16_ADDR_CNT_L);
      chk("fall", 16'h0005, w);
      $display("clock test done");
      wr16(`T16_ADDR_CMPA_L, 16'h0005);
      wr16(`T16_ADDR_CNT_L, 16'h0003);
      wr8(`T16_ADDR_FLAGS, 8'hff);
      wr8(`T16_ADDR_CTRL_B, 8'h07);
      u_pin_driver.pulse(2);
      rd8(`T16_ADDR_FLAGS);
      chk("early", 16'h0000, d);
      u_pin_driver.pulse(1);
      rd8(`T16_ADDR_FLAGS);
      chk("match", 16'h0002, d);
      @(posedge clk);
      gie <= 1'b1;
      wr8(`T16_ADDR_MASK, 8'h02);
      #1 chk("req", 16'h0002, req);
      wr8(`T16_ADDR_MASK, 8'h00);
      #1 chk("masked", 16'h0000, req);
      wr8(`T16_ADDR_FLAGS, 8'h02);
      rd8(`T16_ADDR_FLAGS);
      chk("w1c", 16'h0000, d);
      wr16(`T16_ADDR_CNT_L, 16'h0005);
      u_pin_driver.pulse(1);
      rd8(`T16_ADDR_FLAGS);
      chk("blocked", 16'h0000, d);
      wr8(`T16_ADDR_CTRL_B, 8'h0f);
      wr8(`T16_ADDR_CTRL_A, 8'h50);
      wr8(`T16_ADDR_FORCE, 8'hc0);
      #1 chk("wave", 16'h000c, {wa, wb, wa_oe_n, wb_oe_n});
      rd8(`T16_ADDR_FLAGS);
      chk("forced", 16'h0000, d);
      rd16(`T16_ADDR_CNT_L);
      chk("noclr", 16'h0006, w);
      wr8(`T16_ADDR_CTRL_B, 8'h00);
      $display("compare test done");
      wr16(`T16_ADDR_CNT_L, 16'h0042);
      u_pin_driver.cap_to(1'b0);
      rd16(`T16_ADDR_CAP_L);
      chk("capfall", 16'h0042, w);
      rd8(`T16_ADDR_FLAGS);
      chk("capflag", 16'h0020, d);
      @(posedge clk);
      ack <= 4'h8;
      @(posedge clk);
      ack <= 4'h0;
      rd8(`T16_ADDR_FLAGS);
      chk("ack", 16'h0000, d);
      wr8(`T16_ADDR_CTRL_B, 8'h40);
      wr16(`T16_ADDR_CNT_L, 16'h0077);
      u_pin_driver.cap_to(1'b1);
      wr16(`T16_ADDR_CNT_L, 16'h0088);
      u_pin_driver.cap_to(1'b0);
      rd16(`T16_ADDR_CAP_L);
      chk("caprise", 16'h0077, w);
      wr16(`T16_ADDR_CNT_L, 16'h0099);
      wr8(`T16_ADDR_CTRL_B, 8'h80);
      asel <= 1'b1;
      repeat (8) @(posedge clk);
      ana <= 1'b0;
      repeat (2) @(posedge clk);
      ana <= 1'b1;
      repeat (8) @(posedge clk);
      rd16(`T16_ADDR_CAP_L);
      chk("glitch", 16'h0077, w);
      @(posedge clk);
      ana <= 1'b0;
      repeat (10) @(posedge clk);
      rd16(`T16_ADDR_CAP_L);
      chk("analog", 16'h0099, w);
      wr16(`T16_ADDR_CNT_L, 16'hffff);
      wr8(`T16_ADDR_CTRL_B, 8'h01);
      wr8(`T16_ADDR_CTRL_B, 8'h00);
      rd8(`T16_ADDR_FLAGS);
      chk("ovf", 16'h0001, d & 8'h01);
      $display("capture test done");
      wrap_up;
   end
endmodule // timer16_tb
